// [hdl/cdsd_params.svh]
// Constants for the clock divider sync, swallow and delay control block
`ifndef CDSD_PARAMS_SVH
`define CDSD_PARAMS_SVH

// Serial frame layout, shifted in MSB first: data, register address, chip address
`define CDSD_FRAME_BITS 16
`define CDSD_DATA_BITS 9
`define CDSD_REGA_BITS 4
`define CDSD_CHIP_BITS 3
`define CDSD_DATA_MSB 15
`define CDSD_DATA_LSB 7
`define CDSD_REGA_MSB 6
`define CDSD_REGA_LSB 3
`define CDSD_CHIP_MSB 2
`define CDSD_CHIP_LSB 0
`define CDSD_BCAST_ADDR 3'h7

// Register addresses
`define CDSD_REG_DIVIDE 4'h2
`define CDSD_REG_SERIAL_EXTERNAL_TRIGGER_PIN 4'h3
`define CDSD_REG_CONTROL 4'h4
`define CDSD_REG_LAUNCH 4'h6
`define CDSD_REG_FINE 4'h7

// Field positions
`define CDSD_DIV_MSB 2
`define CDSD_DIV_LSB 0
`define CDSD_SER_SYNC_BIT 0
`define CDSD_SER_SLIP_BIT 1
`define CDSD_BCAST_BIT 0
`define CDSD_PIN_SYNC_BIT 1
`define CDSD_PIN_SLIP_BIT 2
`define CDSD_LAUNCH_BIT 2
`define CDSD_FINE_MSB 5
`define CDSD_FINE_LSB 0

// Reset values
`define CDSD_RST_DIV 3'h1
`define CDSD_RST_SER_SYNC 1'h1
`define CDSD_RST_SER_SLIP 1'h0
`define CDSD_RST_BCAST 1'h0
`define CDSD_RST_PIN_SYNC 1'h0
`define CDSD_RST_PIN_SLIP 1'h0
`define CDSD_RST_LAUNCH 1'h1
`define CDSD_RST_FINE 6'h00

// Fine delay: code times step plus offset, in ps
`define CDSD_FINE_MAX 6'h3C
`define CDSD_FINE_STEP_PS 11'h014
`define CDSD_FINE_OFFSET_PS 11'h12C

// Extra input cycles from sync trigger to first launch, on top of the ratio
`define CDSD_SYNC_EXTRA 6'h02

`endif

// [hdl/cdsd_pkg.sv]
// Types for the clock divider sync, swallow and delay control block
package cdsd_pkg;
	typedef enum logic [1:0] {
		CDSD_HALT = 2'b00,
		CDSD_WAIT = 2'b01,
		CDSD_RUN = 2'b10
	} cdsd_div_state_t;
endpackage

// [hdl/cdsd_serial_rx.sv]
// Serial write frame receiver: pin synchronisers, shifter and latch strobe detect
`timescale 1ns/100ps
`include "cdsd_params.svh"
module cdsd_serial_rx (
	input wire logic clk,
	input wire logic srst,
	// Raw serial pins
	input wire logic i_sck,
	input wire logic i_sdi,
	input wire logic i_sle,
	// Received frame
	output logic o_frame_valid,
	output logic [`CDSD_DATA_BITS-1:0] o_frame_data,
	output logic [`CDSD_REGA_BITS-1:0] o_frame_reg,
	output logic [`CDSD_CHIP_BITS-1:0] o_frame_chip
);
	// Oversampled at the system clock, so the serial clock must stay well below a third of it
	logic [2:0] sync1_reg, sync2_reg, prev_reg;
	logic [`CDSD_FRAME_BITS-1:0] shift_reg, shift_next;
	logic valid_reg, valid_next;
	logic sck_rise, sle_rise;

	always_ff @(posedge clk) begin
		if (srst) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
			prev_reg <= 3'h0;
		end else begin
			sync1_reg <= {i_sle, i_sdi, i_sck};
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	always_comb begin
		sck_rise = sync2_reg[0] && !prev_reg[0];
		sle_rise = sync2_reg[2] && !prev_reg[2];
		shift_next = shift_reg;
		if (sck_rise) begin
			shift_next = {shift_reg[`CDSD_FRAME_BITS-2:0], sync2_reg[1]};
		end
		valid_next = sle_rise;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			shift_reg <= 16'h0000;
			valid_reg <= 1'h0;
		end else begin
			shift_reg <= shift_next;
			valid_reg <= valid_next;
		end
	end

	assign o_frame_valid = valid_reg;
	assign o_frame_data = shift_reg[`CDSD_DATA_MSB:`CDSD_DATA_LSB];
	assign o_frame_reg = shift_reg[`CDSD_REGA_MSB:`CDSD_REGA_LSB];
	assign o_frame_chip = shift_reg[`CDSD_CHIP_MSB:`CDSD_CHIP_LSB];
endmodule

// [hdl/cdsd_top.sv]
// Clock divider control: addressing, sync, cycle swallow, launch edge and fine delay
`timescale 1ns/100ps
`include "cdsd_params.svh"
// Operation
// - Accept frames matching three-pin strapped chip address
// - Broadcast enabled: also accept chip address 111
// - Control bit 0 gates broadcast reception
// - Strap 111 works individually when others disabled
// - Sync restarts divider, ratio-dependent fixed latency
// - Three-bit divide field, one code bypasses
// - Each swallow blocks exactly one input period
// - Launch edge bit: 1 rising, 0 falling
// - Falling launch advances output half period
// - Six-bit fine code, 0-60, 20ps steps
// - Fine delay equals code times 20ps plus 300ps
// - Sync and swallow from pin or serial
// - Pin triggers on rising edge when enabled
// - Serial sync level-held, serial swallow rising-edge
// - Frame: 9 data, 4 address, 3 chip, latched
module cdsd_top
	import cdsd_pkg::*;
(
	// Clock and reset; the clock is the input clock being divided
	input wire logic I_CLOCK,
	input wire logic I_SRST,
	// Serial port pins
	input wire logic I_SERIAL_CLOCK,
	input wire logic I_SERIAL_IN_LINE,
	input wire logic I_SERIAL_LATCH_STROBE,
	// Chip address straps
	input wire logic I_CHIP_ADDR_STRAP_BIT0,
	input wire logic I_CHIP_ADDR_STRAP_BIT1,
	input wire logic I_CHIP_ADDR_STRAP_BIT2,
	// Trigger pin
	input wire logic I_EXTERNAL_TRIGGER_PIN,
	// Divided output
	output logic O_DIV_CLOCK,
	output logic O_LAUNCH_PULSE,
	// Analog delay controls
	output logic O_LAUNCH_EDGE_RISING,
	output logic [5:0] O_FINE_DELAY_CODE,
	output logic [10:0] O_FINE_DELAY_PS
);
	// Divide table: 0 bypass, then powers of two up to 32; spare codes stay at 32
	function automatic logic [5:0] ratio_of(input logic [2:0] code);
		logic [5:0] r;
		r = 6'h20;
		case (code)
			3'h0: r = 6'h01;
			3'h1: r = 6'h02;
			3'h2: r = 6'h04;
			3'h3: r = 6'h08;
			3'h4: r = 6'h10;
			3'h5: r = 6'h20;
			default: r = 6'h20;
		endcase
		return r;
	endfunction

	// Write strobe for one register address
	function automatic logic reg_write(input logic hit, input logic [3:0] ra, input logic [3:0] target);
		return hit && (ra == target);
	endfunction

	// Pin synchronisers
	// Straps ride the same two flops and are read as static levels
	logic [3:0] pin_s1_reg, pin_s2_reg;
	logic external_trigger_pin_prev_reg;
	logic [2:0] strap;
	logic pin_rise;

	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			pin_s1_reg <= 4'h0;
			pin_s2_reg <= 4'h0;
			external_trigger_pin_prev_reg <= 1'h0;
		end else begin
			pin_s1_reg <= {I_EXTERNAL_TRIGGER_PIN, I_CHIP_ADDR_STRAP_BIT2, I_CHIP_ADDR_STRAP_BIT1,
				I_CHIP_ADDR_STRAP_BIT0};
			pin_s2_reg <= pin_s1_reg;
			external_trigger_pin_prev_reg <= pin_s2_reg[3];
		end
	end

	assign strap = pin_s2_reg[2:0];
	assign pin_rise = pin_s2_reg[3] && !external_trigger_pin_prev_reg;

	// Serial frame receiver
	logic frame_valid;
	logic [8:0] frame_data;
	logic [3:0] frame_reg;
	logic [2:0] frame_chip;

	cdsd_serial_rx u_rx (
		.clk(I_CLOCK),
		.srst(I_SRST),
		.i_sck(I_SERIAL_CLOCK),
		.i_sdi(I_SERIAL_IN_LINE),
		.i_sle(I_SERIAL_LATCH_STROBE),
		.o_frame_valid(frame_valid),
		.o_frame_data(frame_data),
		.o_frame_reg(frame_reg),
		.o_frame_chip(frame_chip)
	);

	// Control registers
	logic [2:0] div_code_reg, div_code_next;
	logic ser_sync_reg, ser_sync_next;
	logic ser_slip_reg, ser_slip_next;
	logic bcast_reg, bcast_next;
	logic pin_sync_en_reg, pin_sync_en_next;
	logic pin_slip_en_reg, pin_slip_en_next;
	logic launch_rise_reg, launch_rise_next;
	logic [5:0] fine_reg, fine_next;
	logic addr_hit, wr;

	always_comb begin
		// Strap 111 also matches directly, so it stays reachable with broadcast off
		addr_hit = (frame_chip == strap) || (bcast_reg && frame_chip == `CDSD_BCAST_ADDR);
		wr = frame_valid && addr_hit;
		div_code_next = div_code_reg;
		ser_sync_next = ser_sync_reg;
		ser_slip_next = ser_slip_reg;
		bcast_next = bcast_reg;
		pin_sync_en_next = pin_sync_en_reg;
		pin_slip_en_next = pin_slip_en_reg;
		launch_rise_next = launch_rise_reg;
		fine_next = fine_reg;
		if (reg_write(wr, frame_reg, `CDSD_REG_DIVIDE)) begin
			div_code_next = frame_data[`CDSD_DIV_MSB:`CDSD_DIV_LSB];
		end else if (reg_write(wr, frame_reg, `CDSD_REG_SERIAL_EXTERNAL_TRIGGER_PIN)) begin
			ser_sync_next = frame_data[`CDSD_SER_SYNC_BIT];
			ser_slip_next = frame_data[`CDSD_SER_SLIP_BIT];
		end else if (reg_write(wr, frame_reg, `CDSD_REG_CONTROL)) begin
			bcast_next = frame_data[`CDSD_BCAST_BIT];
			pin_sync_en_next = frame_data[`CDSD_PIN_SYNC_BIT];
			pin_slip_en_next = frame_data[`CDSD_PIN_SLIP_BIT];
		end else if (reg_write(wr, frame_reg, `CDSD_REG_LAUNCH)) begin
			launch_rise_next = frame_data[`CDSD_LAUNCH_BIT];
		end else if (reg_write(wr, frame_reg, `CDSD_REG_FINE)) begin
			fine_next = frame_data[`CDSD_FINE_MSB:`CDSD_FINE_LSB];
		end
	end

	// Write-only registers: this block has no read-back path
	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			div_code_reg <= `CDSD_RST_DIV;
			ser_sync_reg <= `CDSD_RST_SER_SYNC;
			ser_slip_reg <= `CDSD_RST_SER_SLIP;
			bcast_reg <= `CDSD_RST_BCAST;
			pin_sync_en_reg <= `CDSD_RST_PIN_SYNC;
			pin_slip_en_reg <= `CDSD_RST_PIN_SLIP;
			launch_rise_reg <= `CDSD_RST_LAUNCH;
			fine_reg <= `CDSD_RST_FINE;
		end else begin
			div_code_reg <= div_code_next;
			ser_sync_reg <= ser_sync_next;
			ser_slip_reg <= ser_slip_next;
			bcast_reg <= bcast_next;
			pin_sync_en_reg <= pin_sync_en_next;
			pin_slip_en_reg <= pin_slip_en_next;
			launch_rise_reg <= launch_rise_next;
			fine_reg <= fine_next;
		end
	end

	// Trigger sources
	logic ser_sync_prev_reg, ser_slip_prev_reg;
	logic sync_evt, slip_evt, held;

	// Previous values reset to the register resets, so release makes no false edge
	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			ser_sync_prev_reg <= `CDSD_RST_SER_SYNC;
			ser_slip_prev_reg <= `CDSD_RST_SER_SLIP;
		end else begin
			ser_sync_prev_reg <= ser_sync_reg;
			ser_slip_prev_reg <= ser_slip_reg;
		end
	end

	always_comb begin
		// With pin sync off, serial sync low holds the divider stopped; its rise is the restart
		held = !pin_sync_en_reg && !ser_sync_reg;
		sync_evt = pin_sync_en_reg ? pin_rise : (ser_sync_reg && !ser_sync_prev_reg);
		slip_evt = pin_slip_en_reg ? pin_rise : (ser_slip_reg && !ser_slip_prev_reg);
	end

	// Divider
	cdsd_div_state_t state_reg, state_next;
	logic [5:0] ratio;
	logic [5:0] ratio_reg, ratio_next;
	logic [5:0] cnt_reg, cnt_next;
	logic [5:0] wait_reg, wait_next;
	logic step;
	logic div_clk_reg, div_clk_next;
	logic launch_reg, launch_next;

	always_comb begin
		ratio = ratio_of(div_code_reg);
		ratio_next = ratio_reg;
		state_next = state_reg;
		cnt_next = cnt_reg;
		wait_next = wait_reg;
		step = 1'b0;
		// Hold outranks sync, and sync outranks swallow when both arrive
		if (held) begin
			state_next = CDSD_HALT;
			cnt_next = 6'h00;
		end else if (sync_evt) begin
			// Same wait on every device with the same ratio, so outputs line up
			state_next = CDSD_WAIT;
			cnt_next = 6'h00;
			wait_next = ratio + `CDSD_SYNC_EXTRA - 6'h01;
		end else begin
			case (state_reg)
				CDSD_HALT: begin
					cnt_next = 6'h00;
				end
				CDSD_WAIT: begin
					// Count down to zero, then the launch cycle
					if (wait_reg == 6'h00) begin
						state_next = CDSD_RUN;
						cnt_next = 6'h00;
						step = 1'b1;
					end else begin
						wait_next = wait_reg - 6'h01;
					end
				end
				CDSD_RUN: begin
					if (!slip_evt) begin
						// Counted cycle: counter advances; a swallow freezes it for exactly one input period
						step = 1'b1;
						cnt_next = (cnt_reg >= ratio_reg - 6'h01) ? 6'h00 : cnt_reg + 6'h01;
					end
				end
				default: begin
					state_next = CDSD_HALT;
				end
			endcase
		end
		// A new code waits for a period start, so no period is cut short or glitched
		if ((state_next != CDSD_RUN) || (cnt_next == 6'h00)) begin
			ratio_next = ratio;
		end
		// Only a counted cycle launches; a swallowed one never does
		launch_next = (state_next == CDSD_RUN) && step && (cnt_next == 6'h00);
		div_clk_next = (state_next == CDSD_RUN) && ((ratio_next == 6'h01) || (cnt_next < {1'b0, ratio_next[5:1]}));
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			state_reg <= CDSD_RUN;
			ratio_reg <= ratio_of(`CDSD_RST_DIV);
			cnt_reg <= 6'h00;
			wait_reg <= 6'h00;
			div_clk_reg <= 1'h0;
			launch_reg <= 1'h0;
		end else begin
			state_reg <= state_next;
			ratio_reg <= ratio_next;
			cnt_reg <= cnt_next;
			wait_reg <= wait_next;
			div_clk_reg <= div_clk_next;
			launch_reg <= launch_next;
		end
	end

	// Fine delay setting; codes above the top step are clamped
	logic [5:0] fine_code;
	logic [10:0] fine_ps_reg, fine_ps_next;
	logic [5:0] fine_out_reg;

	always_comb begin
		fine_code = (fine_reg > `CDSD_FINE_MAX) ? `CDSD_FINE_MAX : fine_reg;
		fine_ps_next = 11'({5'h00, fine_code} * `CDSD_FINE_STEP_PS) + `CDSD_FINE_OFFSET_PS;
	end

	// Code and total move together in one register stage
	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			fine_out_reg <= `CDSD_RST_FINE;
			fine_ps_reg <= `CDSD_FINE_OFFSET_PS;
		end else begin
			fine_out_reg <= fine_code;
			fine_ps_reg <= fine_ps_next;
		end
	end

	assign O_DIV_CLOCK = div_clk_reg;
	assign O_LAUNCH_PULSE = launch_reg;
	assign O_LAUNCH_EDGE_RISING = launch_rise_reg;
	assign O_FINE_DELAY_CODE = fine_out_reg;
	assign O_FINE_DELAY_PS = fine_ps_reg;
endmodule

// [dv/cdsd_top_assertions.sv]
// Port checks for the divider control block
`timescale 1ns/100ps
module cdsd_top_assertions (
	input wire logic I_CLOCK,
	input wire logic I_SRST,
	input wire logic I_SERIAL_LATCH_STROBE,
	input wire logic O_DIV_CLOCK,
	input wire logic O_LAUNCH_PULSE,
	input wire logic O_LAUNCH_EDGE_RISING,
	input wire logic [5:0] O_FINE_DELAY_CODE,
	input wire logic [10:0] O_FINE_DELAY_PS
);
	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (I_SRST);
	// No frame can land once the strobe has idled this long
	sequence quiet_s;
		!I_SERIAL_LATCH_STROBE [*8];
	endsequence
	fine_hold_a: assert property (quiet_s |=> $stable(O_FINE_DELAY_CODE))
		else $error("fine code moved without a frame");
	edge_hold_a: assert property (quiet_s |=> $stable(O_LAUNCH_EDGE_RISING))
		else $error("launch edge moved without a frame");
	fine_ps_a: assert property (O_FINE_DELAY_PS == 11'(O_FINE_DELAY_CODE) * 11'h014 + 11'h12C)
		else $error("fine delay total wrong");
	fine_max_a: assert property (O_FINE_DELAY_CODE <= 6'h3C)
		else $error("fine code above range");
	pulse_div_a: assert property (O_LAUNCH_PULSE |-> O_DIV_CLOCK)
		else $error("launch while divided clock low");
	rise_pulse_a: assert property ($rose(O_DIV_CLOCK) |-> O_LAUNCH_PULSE)
		else $error("divided clock rose off period start");
	first_pulse_a: assert property ($fell(I_SRST) |-> ##[1:3] O_LAUNCH_PULSE)
		else $error("no launch after reset");
	reset_out_a: assert property (disable iff (1'b0) I_SRST |=> !O_DIV_CLOCK && !O_LAUNCH_PULSE
		&& O_LAUNCH_EDGE_RISING && O_FINE_DELAY_CODE == 6'h00)
		else $error("reset outputs wrong");
endmodule
bind cdsd_top cdsd_top_assertions u_chk (.I_CLOCK(I_CLOCK), .I_SRST(I_SRST),
	.I_SERIAL_LATCH_STROBE(I_SERIAL_LATCH_STROBE), .O_DIV_CLOCK(O_DIV_CLOCK),
	.O_LAUNCH_PULSE(O_LAUNCH_PULSE), .O_LAUNCH_EDGE_RISING(O_LAUNCH_EDGE_RISING),
	.O_FINE_DELAY_CODE(O_FINE_DELAY_CODE), .O_FINE_DELAY_PS(O_FINE_DELAY_PS));

// [dv/cdsd_host_model.sv]
// Serial host and trigger pin model
`timescale 1ns/100ps
module cdsd_host_model (
	input wire logic clk,
	output logic sck,
	output logic serial_in_line,
	output logic serial_latch_strobe,
	output logic external_trigger_pin
);
	initial begin
		sck = 1'b0;
		serial_in_line = 1'b0;
		serial_latch_strobe = 1'b0;
		external_trigger_pin = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Data, register, chip, MSB first, then strobe
	task automatic wr(input logic [2:0] chip, input logic [3:0] ra, input logic [8:0] d);
		logic [15:0] f;
		f = {d, ra, chip};
		for (int i = 15; i >= 0; i--) begin
			serial_in_line <= f[i];
			tick(4);
			sck <= 1'b1;
			tick(4);
			sck <= 1'b0;
		end
		// Released line shows no stale bit
		serial_in_line <= ~f[0];
		tick(4);
		serial_latch_strobe <= 1'b1;
		tick(4);
		serial_latch_strobe <= 1'b0;
		tick(12);
	endtask
	task automatic pulse();
		external_trigger_pin <= 1'b1;
		tick(4);
		external_trigger_pin <= 1'b0;
		tick(4);
	endtask
endmodule

// [dv/cdsd_top_tb_top.sv]
// Self-checking bench for the divider control block
`timescale 1ns/100ps
`include "cdsd_params.svh"
module cdsd_top_tb_top;
	logic clk;
	logic srst;
	logic [2:0] strap;
	logic sck, serial_in_line, serial_latch_strobe, external_trigger_pin;
	logic div_clk, pulse, edge_r;
	logic [5:0] code;
	logic [10:0] ps;
	int err_total;
	int check_count;
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	cdsd_host_model u_host (.clk(clk), .sck(sck), .serial_in_line(serial_in_line), .serial_latch_strobe(serial_latch_strobe), .external_trigger_pin(external_trigger_pin));
	cdsd_top u_dut (.I_CLOCK(clk), .I_SRST(srst), .I_SERIAL_CLOCK(sck), .I_SERIAL_IN_LINE(serial_in_line),
		.I_SERIAL_LATCH_STROBE(serial_latch_strobe), .I_CHIP_ADDR_STRAP_BIT0(strap[0]), .I_CHIP_ADDR_STRAP_BIT1(strap[1]),
		.I_CHIP_ADDR_STRAP_BIT2(strap[2]), .I_EXTERNAL_TRIGGER_PIN(external_trigger_pin), .O_DIV_CLOCK(div_clk),
		.O_LAUNCH_PULSE(pulse), .O_LAUNCH_EDGE_RISING(edge_r), .O_FINE_DELAY_CODE(code),
		.O_FINE_DELAY_PS(ps));
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [10:0] e, input logic [10:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %0d seen %0d", what, e, g);
		end
	endtask
	task automatic fchk(input logic [5:0] e);
		chk("fine code", {5'h00, e}, {5'h00, code});
		chk("fine ps", 11'(e) * 11'h014 + 11'h12C, ps);
	endtask
	task automatic wr(input logic [3:0] ra, input logic [8:0] d);
		u_host.wr(3'h2, ra, d);
	endtask
	// Longest spacing of launch pulses over n cycles; 0 if none, 1 for a lone pulse
	task automatic mon(input int n, output int mx);
		int g;
		g = -1;
		mx = 0;
		repeat (n) begin
			@(posedge clk);
			if (g >= 0) g++;
			if (pulse === 1'b1) begin
				if (g > mx) mx = g;
				if (mx == 0) mx = 1;
				g = 0;
			end
		end
	endtask
	// Cycles from trigger pin rise to first launch
	task automatic lat(output int l);
		fork
			u_host.pulse();
			begin
				repeat (6) @(posedge clk);
				l = 6;
				while (pulse !== 1'b1 && l < 200) begin
					@(posedge clk);
					l++;
				end
				if (l >= 200) begin
					err_total++;
					$display("unexpected sync launch: expected within 200 cycles seen none");
				end
			end
		join
	endtask
	task automatic t_reset();
		int mx;
		mon(20, mx);
		chk("edge after reset", 11'h001, {10'h000, edge_r});
		fchk(6'h00);
		chk("reset gap", 11'h002, 11'(mx));
	endtask
	task automatic t_addr();
		u_host.wr(3'h5, `CDSD_REG_FINE, 9'h011);
		fchk(6'h00);
		wr(`CDSD_REG_FINE, 9'h011);
		fchk(6'h11);
		u_host.wr(3'h7, `CDSD_REG_FINE, 9'h022);
		fchk(6'h11);
		wr(`CDSD_REG_CONTROL, 9'h001);
		u_host.wr(3'h7, `CDSD_REG_FINE, 9'h022);
		fchk(6'h22);
		wr(`CDSD_REG_CONTROL, 9'h000);
		strap <= 3'h7;
		u_host.wr(3'h7, `CDSD_REG_FINE, 9'h033);
		fchk(6'h33);
		strap <= 3'h2;
	endtask
	task automatic t_fine();
		wr(`CDSD_REG_FINE, 9'h03C);
		fchk(6'h3C);
		wr(`CDSD_REG_FINE, 9'h03F);
		fchk(6'h3C);
		wr(`CDSD_REG_FINE, 9'h000);
		fchk(6'h00);
	endtask
	task automatic t_ratio();
		int mx;
		int gaps[8] = '{1, 2, 4, 8, 16, 32, 32, 32};
		for (int c = 0; c < 8; c++) begin
			wr(`CDSD_REG_DIVIDE, 9'(c));
			mon(80, mx);
			chk("ratio gap", 11'(gaps[c]), 11'(mx));
			if (c == 0) chk("bypass clock", 11'h001, {10'h000, div_clk});
		end
		wr(`CDSD_REG_DIVIDE, 9'h001);
	endtask
	// One swallow by serial port, one by pin, then falling launch edge
	task automatic t_slip();
		int mx;
		fork
			wr(`CDSD_REG_SERIAL_EXTERNAL_TRIGGER_PIN, 9'h003);
			mon(200, mx);
		join
		chk("serial swallow gap", 11'h003, 11'(mx));
		wr(`CDSD_REG_SERIAL_EXTERNAL_TRIGGER_PIN, 9'h001);
		fork
			u_host.pulse();
			mon(40, mx);
		join
		chk("pin disabled gap", 11'h002, 11'(mx));
		wr(`CDSD_REG_CONTROL, 9'h004);
		fork
			u_host.pulse();
			mon(40, mx);
		join
		chk("pin swallow gap", 11'h003, 11'(mx));
		wr(`CDSD_REG_LAUNCH, 9'h000);
		chk("falling edge", 11'h000, {10'h000, edge_r});
		wr(`CDSD_REG_LAUNCH, 9'h004);
		chk("rising edge", 11'h001, {10'h000, edge_r});
	endtask
	task automatic t_sync();
		int a, b, c, mx;
		wr(`CDSD_REG_DIVIDE, 9'h003);
		wr(`CDSD_REG_CONTROL, 9'h002);
		lat(a);
		chk("sync latency", 11'h00E, 11'(a));
		repeat (3) @(posedge clk);
		lat(b);
		chk("sync latency repeat", 11'(a), 11'(b));
		wr(`CDSD_REG_DIVIDE, 9'h005);
		lat(c);
		chk("sync latency ratio", 11'(a + 24), 11'(c));
		wr(`CDSD_REG_CONTROL, 9'h000);
		wr(`CDSD_REG_DIVIDE, 9'h001);
		wr(`CDSD_REG_SERIAL_EXTERNAL_TRIGGER_PIN, 9'h000);
		mon(60, mx);
		chk("halted", 11'h000, 11'(mx));
		chk("halted clock", 11'h000, {10'h000, div_clk});
		wr(`CDSD_REG_SERIAL_EXTERNAL_TRIGGER_PIN, 9'h001);
		mon(40, mx);
		chk("restarted", 11'h002, 11'(mx));
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		stop_test();
	end
	initial begin
		err_total = 0;
		check_count = 0;
		srst = 1'b1;
		strap = 3'h2;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_addr();
		t_fine();
		t_ratio();
		t_slip();
		t_sync();
		stop_test();
	end
endmodule
